// ===== adc_fmt_defs.svh
// Register offsets, field positions, reset values and codes for the converter result/reference block
`ifndef ADC_FMT_DEFS_SVH
`define ADC_FMT_DEFS_SVH

`define OFS_CHAN_REF 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_RESULT_LOW 8'h08
`define OFS_RESULT_HIGH 8'h0C
`define OFS_STATUS 8'h10
`define OFS_MISC 8'h14
`define OFS_CONV_IN 8'h18

`define CHR_REF_HI 7
`define CHR_REF_LO 6
`define CHR_LEFT_ADJ 5
`define CHR_CHAN_MSB 4
`define CTB_BIPOLAR 7
`define STS_DONE 0
`define STS_BUSY 1
`define STS_ENABLE 2
`define STS_START 3
`define MISC_REF_OUT_EN 1
`define MISC_EXT_REF_EN 0

`define RST_CHAN_REF 8'h00
`define RST_CTRL_B 8'h00
`define RST_MISC 8'h00
`define RST_STATUS 8'h00

`define CODE_ZERO 10'h000
`define CODE_FULL 10'h3FF
`define CODE_BI_MIN 10'h200
`define CODE_BI_MAX 10'h1FF
`define CHAN_TEMP_SENSOR 5'h0B
`define CONV_CYCLES 8'h0D

`endif

// ===== adc_fmt_pkg.sv
// Types shared by the converter result and reference-output block
package adc_fmt_pkg;
	typedef enum logic [1:0] {
		REF_SUPPLY = 2'b00,
		REF_EXTERNAL = 2'b01,
		REF_INT_1V1 = 2'b10,
		REF_INT_2V56 = 2'b11
	} ref_src_t;

	typedef enum logic [1:0] {
		CONV_SINGLE = 2'b00,
		CONV_UNIPOLAR = 2'b01,
		CONV_BIPOLAR = 2'b10
	} conv_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONVERT = 2'b01,
		ST_FINISH = 2'b10
	} conv_state_t;
endpackage : adc_fmt_pkg

// ===== result_encoder.sv
// Encodes a raw signed sample into the 10-bit result code for the active conversion kind
`timescale 1ns/1ps
`include "adc_fmt_defs.svh"
module result_encoder #(
	parameter int RAW_W = 16
) (
	// Inputs
	input wire logic signed [RAW_W-1:0] raw_diff,
	input wire adc_fmt_pkg::conv_kind_t kind,
	input wire logic gain_20x,
	// Output
	output logic [9:0] code
);
	import adc_fmt_pkg::*;

	logic signed [RAW_W+5:0] scaled;
	logic signed [RAW_W+5:0] lim_hi;
	logic signed [RAW_W+5:0] lim_lo;

	always_comb begin
		// Differential paths carry the gain; raw is in single-ended LSB units
		scaled = (RAW_W+6)'(raw_diff);
		if (kind != CONV_SINGLE) begin
			scaled = gain_20x ? scaled * (RAW_W+6)'(20) : scaled * (RAW_W+6)'(8);
		end
		if (kind == CONV_BIPOLAR) begin
			// Bipolar uses half the scale per volt, so halve
			scaled = scaled >>> 1;
			lim_hi = (RAW_W+6)'(511);
			lim_lo = -(RAW_W+6)'(512);
		end else begin
			lim_hi = (RAW_W+6)'(1023);
			lim_lo = '0;
		end
		if (scaled > lim_hi) begin
			code = (kind == CONV_BIPOLAR) ? `CODE_BI_MAX : `CODE_FULL;
		end else if (scaled < lim_lo) begin
			// Negative difference saturates to zero unless bipolar
			code = (kind == CONV_BIPOLAR) ? `CODE_BI_MIN : `CODE_ZERO;
		end else begin
			code = scaled[9:0];
		end
	end
endmodule : result_encoder

// ===== ref_out_ctrl.sv
// Decodes the reference selection and drives the reference output pin enable
`timescale 1ns/1ps
module ref_out_ctrl (
	// Controls
	input wire logic ref_select_hi,
	input wire logic ref_select_lo,
	input wire logic ext_ref_en,
	input wire logic ref_output_enable,
	input wire logic conv_enable,
	// Results
	output adc_fmt_pkg::ref_src_t ref_src,
	output logic ref_out_oe,
	output logic ref_out_2v56
);
	import adc_fmt_pkg::*;

	always_comb begin
		if (!ref_select_lo) begin
			ref_src = ext_ref_en ? REF_EXTERNAL : REF_SUPPLY;
		end else begin
			ref_src = ref_select_hi ? REF_INT_2V56 : REF_INT_1V1;
		end
		// Pin stays floating unless enabled, powered and an internal reference is chosen
		ref_out_oe = ref_output_enable && conv_enable && ref_select_lo;
		ref_out_2v56 = ref_select_hi;
	end
endmodule : ref_out_ctrl

// ===== adc_result_format_and_ref_output.sv
// Converter digital side: AXI4-Lite registers, result encoding and reference output control
`timescale 1ns/1ps
`include "adc_fmt_defs.svh"

module adc_result_format_and_ref_output #(
	parameter int RAW_W = 16,
	parameter logic [7:0] CONV_CYCLES = `CONV_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog front end sample, from another domain
	input wire logic [RAW_W-1:0] raw_sample,
	// Reference output pin control
	output logic ref_out_oe,
	output logic ref_out_2v56,
	output adc_fmt_pkg::ref_src_t ref_src
);
	import adc_fmt_pkg::*;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Register state
	logic [7:0] chan_ref_ff, nxt_chan_ref;
	logic [7:0] ctrl_b_ff, nxt_ctrl_b;
	logic [7:0] misc_ff, nxt_misc;
	logic conv_en_ff, nxt_conv_en;
	logic done_ff, nxt_done;
	logic [9:0] result_ff, nxt_result;
	logic [4:0] lock_chan_ff, nxt_lock_chan;
	conv_kind_t lock_kind_ff, nxt_lock_kind;
	conv_state_t state_ff, nxt_state;
	logic [7:0] cnt_ff, nxt_cnt;
	// Bus state
	logic aw_hold_ff, nxt_aw_hold;
	logic w_hold_ff, nxt_w_hold;
	logic [7:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	// Sample synchroniser
	logic [RAW_W-1:0] sync1_ff, sync2_ff;

	logic [9:0] enc_code;
	logic do_write;
	logic start_req;
	logic [15:0] result_view;

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == `OFS_CHAN_REF) || (a == `OFS_CTRL_B) || (a == `OFS_RESULT_LOW) ||
			(a == `OFS_RESULT_HIGH) || (a == `OFS_STATUS) || (a == `OFS_MISC);
	endfunction : addr_known

	function automatic conv_kind_t kind_of(input logic [4:0] chan, input logic bipolar);
		if (!chan[4]) begin
			kind_of = CONV_SINGLE;
		end else begin
			kind_of = bipolar ? CONV_BIPOLAR : CONV_UNIPOLAR;
		end
	endfunction : kind_of

	result_encoder #(
		.RAW_W(RAW_W)
	) u_enc (
		.raw_diff(sync2_ff),
		.kind(lock_kind_ff),
		.gain_20x(lock_chan_ff[0]),
		.code(enc_code)
	);

	ref_out_ctrl u_ref (
		.ref_select_hi(chan_ref_ff[`CHR_REF_HI]),
		.ref_select_lo(chan_ref_ff[`CHR_REF_LO]),
		.ext_ref_en(misc_ff[`MISC_EXT_REF_EN]),
		.ref_output_enable(misc_ff[`MISC_REF_OUT_EN]),
		.conv_enable(conv_en_ff),
		.ref_src(ref_src),
		.ref_out_oe(ref_out_oe),
		.ref_out_2v56(ref_out_2v56)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= raw_sample;
			sync2_ff <= sync1_ff;
		end
	end

	// Alignment is applied on read, so a change acts at once
	always_comb begin
		if (chan_ref_ff[`CHR_LEFT_ADJ]) begin
			result_view = {result_ff, 6'h00};
		end else begin
			result_view = {6'h00, result_ff};
		end
	end

	assign do_write = (aw_hold_ff || s_axi_awvalid) && (w_hold_ff || s_axi_wvalid) && !bvalid_ff;
	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready = !w_hold_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_comb begin
		logic [7:0] wa;
		logic [31:0] wd;
		logic [3:0] ws;
		wa = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
		wd = w_hold_ff ? wdata_ff : s_axi_wdata;
		ws = w_hold_ff ? wstrb_ff : s_axi_wstrb;
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold = w_hold_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		nxt_chan_ref = chan_ref_ff;
		nxt_ctrl_b = ctrl_b_ff;
		nxt_misc = misc_ff;
		nxt_conv_en = conv_en_ff;
		nxt_done = done_ff;
		start_req = 1'b0;
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_axi_awready && !do_write) begin
			nxt_aw_hold = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready && !do_write) begin
			nxt_w_hold = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (do_write) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = addr_known(wa) ? RESP_OKAY : RESP_SLVERR;
			if (ws[0]) begin
				case (wa)
					`OFS_CHAN_REF: begin
						nxt_chan_ref = wd[7:0];
					end
					`OFS_CTRL_B: begin
						nxt_ctrl_b = wd[7:0];
					end
					`OFS_MISC: begin
						nxt_misc = wd[7:0];
					end
					`OFS_STATUS: begin
						nxt_conv_en = wd[`STS_ENABLE];
						start_req = wd[`STS_START] && wd[`STS_ENABLE];
						// Writing one clears the done flag
						if (wd[`STS_DONE]) begin
							nxt_done = 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
		end
		// Completion sets the flag, winning over a simultaneous clear
		if (state_ff == ST_FINISH) begin
			nxt_done = 1'b1;
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				`OFS_CHAN_REF: nxt_rdata = {24'h000000, chan_ref_ff};
				`OFS_CTRL_B: nxt_rdata = {24'h000000, ctrl_b_ff};
				`OFS_MISC: nxt_rdata = {24'h000000, misc_ff};
				`OFS_RESULT_LOW: nxt_rdata = {24'h000000, result_view[7:0]};
				`OFS_RESULT_HIGH: nxt_rdata = {24'h000000, result_view[15:8]};
				`OFS_STATUS: nxt_rdata = {28'h0000000, 1'b0, conv_en_ff, state_ff != ST_IDLE, done_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end
	end

	// Conversion sequencer: channel and mode lock at start
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_lock_chan = lock_chan_ff;
		nxt_lock_kind = lock_kind_ff;
		nxt_result = result_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_req) begin
					nxt_state = ST_CONVERT;
					nxt_cnt = CONV_CYCLES;
					nxt_lock_chan = nxt_chan_ref[`CHR_CHAN_MSB:0];
					nxt_lock_kind = kind_of(nxt_chan_ref[`CHR_CHAN_MSB:0], nxt_ctrl_b[`CTB_BIPOLAR]);
				end
			end
			ST_CONVERT: begin
				if (!conv_en_ff) begin
					nxt_state = ST_IDLE;
				end else if (cnt_ff <= 8'h01) begin
					nxt_state = ST_FINISH;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			ST_FINISH: begin
				// Single 10-bit store keeps both halves from one conversion
				nxt_result = enc_code;
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_ref_ff <= `RST_CHAN_REF;
			ctrl_b_ff <= `RST_CTRL_B;
			misc_ff <= `RST_MISC;
			conv_en_ff <= 1'b0;
			done_ff <= 1'b0;
			result_ff <= 10'h000;
			lock_chan_ff <= 5'h00;
			lock_kind_ff <= CONV_SINGLE;
			state_ff <= ST_IDLE;
			cnt_ff <= 8'h00;
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'b00;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= 2'b00;
		end else begin
			chan_ref_ff <= nxt_chan_ref;
			ctrl_b_ff <= nxt_ctrl_b;
			misc_ff <= nxt_misc;
			conv_en_ff <= nxt_conv_en;
			done_ff <= nxt_done;
			result_ff <= nxt_result;
			lock_chan_ff <= nxt_lock_chan;
			lock_kind_ff <= nxt_lock_kind;
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end
endmodule : adc_result_format_and_ref_output

// ===== adc_fmt_chk.sv
// Port-level checker for the converter result and reference block
`timescale 1ns/1ps
module adc_fmt_chk (
	// Clock, reset and bus
	input wire logic aclk, aresetn,
	input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid, s_axi_rready,
	// Reference pin
	input wire logic ref_out_oe, ref_out_2v56,
	input wire adc_fmt_pkg::ref_src_t ref_src
);
	import adc_fmt_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_RD_UPPER: assert property (s_axi_rvalid && s_axi_rresp == 2'b00 |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	AST_SLVERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h00000000)
		else $error("refused read returned data");
	AST_REF_SRC: assert property (ref_out_oe |-> ref_src == REF_INT_1V1 || ref_src == REF_INT_2V56)
		else $error("pin driven without internal reference");
	AST_REF_LEVEL: assert property (ref_out_oe |-> ref_out_2v56 == (ref_src == REF_INT_2V56))
		else $error("pin level does not follow selection");
	COV_READ: cover property (s_axi_rvalid && s_axi_rready);
	COV_REFUSE: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	COV_PIN_HI: cover property (ref_out_oe && ref_out_2v56);
endmodule : adc_fmt_chk

bind adc_result_format_and_ref_output adc_fmt_chk i_adc_fmt_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.ref_out_oe(ref_out_oe), .ref_out_2v56(ref_out_2v56), .ref_src(ref_src));

// ===== test_adc_result_format_and_ref_output.sv
// Self-checking bench for the converter result and reference block
`timescale 1ns/1ps
module test_adc_result_format_and_ref_output;
	import adc_fmt_pkg::*;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ref_out_oe, ref_out_2v56;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] raw_sample;
	ref_src_t ref_src;
	logic [33:0] exp_q[$];
	logic [33:0] seen;
	int n_fail, comparisons, cyc;
	logic [4:0] chs [10] = '{5'h0B, 5'h0B, 5'h0B, 5'h10, 5'h11, 5'h11, 5'h10, 5'h11, 5'h11, 5'h12};
	bit bips [10] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 0};
	int raws [10] = '{300, -5, 2000, 100, -3, 100, -50, 100, -100, 0};
	adc_result_format_and_ref_output i_adc_result_format_and_ref_output (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .raw_sample(raw_sample),
		.ref_out_oe(ref_out_oe), .ref_out_2v56(ref_out_2v56), .ref_src(ref_src));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic check(input logic [33:0] got, input logic [33:0] expd);
		comparisons++;
		if (got !== expd) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, expd);
		end
	endtask : check
	task automatic summarize();
		if (n_fail == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] resp);
		logic aw_open;
		logic w_open;
		exp_q.push_back({resp, 32'h00000000});
		aw_open = 1'b1;
		w_open = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Each channel is released at its own handshake; both valids rise together, so only the simultaneous case is covered
		while (aw_open || w_open) begin
			@(posedge aclk);
			if (aw_open && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				aw_open = 1'b0;
			end
			if (w_open && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				w_open = 1'b0;
			end
		end
		@(posedge aclk iff s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk iff s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk iff s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd
	function automatic logic [9:0] enc(input logic [4:0] ch, input logic bip, input int raw);
		int v;
		v = ch[4] ? raw * (ch[0] ? 20 : 8) : raw;
		if (ch[4] && bip) begin
			v = v >>> 1;
			v = v > 511 ? 511 : (v < -512 ? -512 : v);
		end else begin
			v = v > 1023 ? 1023 : (v < 0 ? 0 : v);
		end
		return v[9:0];
	endfunction : enc
	task automatic conv(input logic [4:0] ch, input logic bip, input int raw, input logic left);
		logic [9:0] c;
		logic [15:0] r;
		logic [15:0] o;
		c = enc(ch, bip, raw);
		r = left ? {c, 6'h00} : {6'h00, c};
		o = left ? {6'h00, c} : {c, 6'h00};
		raw_sample <= raw[15:0];
		wr(8'h00, {2'b01, left, ch}, 4'hF, 2'b00);
		wr(8'h04, {bip, 7'h00}, 4'hF, 2'b00);
		// Start also clears the old done flag, so done below belongs to this conversion
		wr(8'h10, 8'h0D, 4'hF, 2'b00);
		rd(8'h10, 34'h000000006);
		repeat (30) @(posedge aclk);
		rd(8'h10, 34'h000000005);
		rd(8'h08, {26'h0, r[7:0]});
		rd(8'h0C, {26'h0, r[15:8]});
		wr(8'h00, {2'b01, ~left, ch}, 4'hF, 2'b00);
		rd(8'h08, {26'h0, o[7:0]});
		rd(8'h0C, {26'h0, o[15:8]});
	endtask : conv
	always @(posedge aclk) begin
		if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
			seen = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h00000000};
			check(seen, exp_q.size() > 0 ? exp_q.pop_front() : ~seen);
		end
	end
	// A hang is cut short well past the longest expected run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		n_fail = 0;
		comparisons = 0;
		cyc = 0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, raw_sample} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		seen = $urandom(32'hB909);
		raws[9] = int'($urandom_range(120)) - 60;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (raws[i]) rd(8'(i % 6 * 4), 34'h000000000);
		rd(8'h40, {2'b10, 32'h00000000});
		wr(8'h40, 8'hFF, 4'hF, 2'b10);
		wr(8'h00, 8'h55, 4'h0, 2'b00);
		rd(8'h00, 34'h000000000);
		foreach (chs[i]) conv(chs[i], bips[i], raws[i], i[0]);
		// Clearing enable mid-conversion aborts it: no busy, no done afterwards
		wr(8'h10, 8'h0D, 4'hF, 2'b00);
		wr(8'h10, 8'h00, 4'hF, 2'b00);
		repeat (30) @(posedge aclk);
		rd(8'h10, 34'h000000000);
		// Pin pull-up and digital driver live outside this block and stay off here
		for (int k = 0; k < 32; k++) begin
			wr(8'h00, {k[1:0], 6'h00}, 4'hF, 2'b00);
			wr(8'h14, {6'h00, k[3:2]}, 4'hF, 2'b00);
			wr(8'h10, {5'h00, k[4], 2'b00}, 4'hF, 2'b00);
			@(posedge aclk);
			check({33'h0, ref_out_oe}, {33'h0, k[3] & k[4] & k[0]});
			check({33'h0, ref_out_2v56 & ref_out_oe}, {33'h0, k[1] & k[3] & k[4] & k[0]});
			check({32'h0, ref_src}, {32'h0, k[0] ? {1'b1, k[1]} : {1'b0, k[2]}});
		end
		repeat (4) @(posedge aclk);
		summarize();
	end
endmodule : test_adc_result_format_and_ref_output
